// [design/wkdsp_pkg.sv]
// Package of encodings, field positions and reset values for the wake/irq/display write block
package wkdsp_pkg;

    // Instruction word layout
    localparam int INSTR_W = 16;
    localparam int NIB_W = 4;
    localparam int FLAG_W = 8;
    localparam int DISP_ADDR_W = 5;
    localparam int MEM_ADDR_W = 7;
    localparam int WREG_ADDR_W = 4;

    // Eight-bit opcode prefix in bits 15..8, operand in bits 7..0
    localparam int OP8_HI = 15;
    localparam int OP8_LO = 8;
    localparam logic [7:0] OP8_HOLD_FLAGS = 8'h42;
    localparam logic [7:0] OP8_IRQ_FLAGS = 8'h51;
    localparam logic [7:0] OP8_OUT_TYPE = 8'h01;

    // Seven-bit opcode prefix in bits 15..9 for display RAM writes
    localparam int OP7_HI = 15;
    localparam int OP7_LO = 9;
    localparam logic [6:0] OP7_DISP_FROM_ACC = 7'h03;
    localparam logic [6:0] OP7_DISP_FROM_WREG = 7'h12;
    localparam logic [6:0] OP7_DISP_FROM_IMM = 7'h02;

    // Nine-bit opcode prefix in bits 15..7 for the memory-to-accumulator move
    localparam int OP9_HI = 15;
    localparam int OP9_LO = 7;
    localparam logic [8:0] OP9_ACC_FROM_MEM = 9'h09D;

    // Operand fields
    localparam int IMM8_HI = 7;
    localparam int IMM8_LO = 0;
    localparam int DADDR_HI = 8;
    localparam int DADDR_LO = 4;
    localparam int NIB_HI = 3;
    localparam int NIB_LO = 0;
    localparam int MADDR_HI = 6;
    localparam int MADDR_LO = 0;
    localparam logic [3:0] ACC_FORM_TAIL = 4'h0;

    // Source bit positions shared by both flag sets
    localparam int SRC_DIV0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_PORT = 2;
    localparam int SRC_DIV1 = 4;
    localparam int SRC_TMR1 = 7;

    // Implemented flag bits; bits 3, 5 and 6 have no function
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h97;

    // Reset values
    localparam logic [7:0] HOLD_FLAGS_RST = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] OUT_TYPE_RST = 8'h00;
    localparam logic [3:0] NIB_RST = 4'h0;

    // Last executed operation, reported on a status output
    typedef enum logic [2:0] {
        WKDSP_OP_NONE = 3'h0,
        WKDSP_OP_HOLD = 3'h1,
        WKDSP_OP_IRQ = 3'h2,
        WKDSP_OP_TYPE = 3'h3,
        WKDSP_OP_DISP = 3'h4,
        WKDSP_OP_LOAD = 3'h5
    } wkdsp_op_type;

endpackage

// [design/wkdsp_nibble_ram.sv]
// Display nibble RAM: one write port from the core, one registered read port for the display
`timescale 1ns/1ps
`default_nettype none

module wkdsp_nibble_ram #(
    parameter int DEPTH = 32,
    parameter int ADDR_W = 5,
    parameter int DATA_W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // Read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data_ff
);

    initial begin
        if (DEPTH > (1 << ADDR_W) || DEPTH < 1 || DATA_W < 1) begin
            $error("wkdsp_nibble_ram: depth does not fit the address width");
        end
    end

    // No reset on the array: contents are undefined until software writes them
    logic [DATA_W-1:0] mem_ff [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_ff <= '0;
        end else if (32'(rd_addr) < DEPTH) begin
            rd_data_ff <= mem_ff[rd_addr];
        end else begin
            rd_data_ff <= '0;
        end
    end

endmodule

`default_nettype wire

// [design/wkdsp_exec.sv]
// Execution unit for hold-wake flags, interrupt-accept flags, output type and display RAM writes
//
// How it works
// - each instruction completes in one machine cycle
// - hold-wake load copies operand bits to flags
// - bit I0 wakes on divider zero overflow
// - bit I1 wakes on timer zero underflow
// - bit I2 wakes on port input change
// - bit I4 wakes on divider one overflow
// - bit I7 wakes on timer one underflow
// - interrupt load copies operand bits to flags
// - bit I0 accepts divider zero interrupt
// - bit I1 accepts timer zero interrupt
// - bit I2 accepts port change interrupt
// - bit I4 accepts divider one interrupt
// - bit I7 accepts timer one interrupt
// - direct mode: zero push-pull, one open-drain
// - accumulator nibble written to display RAM
// - working register nibble written to display RAM
// - immediate nibble written to display RAM
// - memory move loads accumulator, updates zero flag
`timescale 1ns/1ps
`default_nettype none

module wkdsp_exec #(
    parameter int DISP_DEPTH = 32,
    parameter int PORT_W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Instruction from the core decoder
    input wire logic instr_valid,
    input wire logic [wkdsp_pkg::INSTR_W-1:0] instr_word,
    // Operands presented by the datapath with the instruction
    input wire logic [wkdsp_pkg::NIB_W-1:0] accumulator,
    input wire logic [wkdsp_pkg::NIB_W-1:0] wreg_rd_data,
    input wire logic [wkdsp_pkg::NIB_W-1:0] mem_rd_data,
    // Accumulator load result
    output logic acc_load_ff,
    output logic [wkdsp_pkg::NIB_W-1:0] acc_load_data_ff,
    output logic zero_flag_ff,
    // Completion and status
    output logic instr_done_ff,
    output logic [2:0] last_op_ff,
    // Event sources on the core clock, one-cycle pulses
    input wire logic div0_overflow,
    input wire logic tmr0_underflow,
    input wire logic div1_overflow,
    input wire logic tmr1_underflow,
    // Change-detect input port pins
    input wire logic [PORT_W-1:0] change_detect_input_port,
    // Hold control
    input wire logic in_hold,
    output logic hold_release_ff,
    // Interrupt acceptance
    output logic [wkdsp_pkg::FLAG_W-1:0] irq_accept_ff,
    // Flag state
    output logic [wkdsp_pkg::FLAG_W-1:0] hold_wake_enable_flags_ff,
    output logic [wkdsp_pkg::FLAG_W-1:0] interrupt_accept_flags_ff,
    // Segment pins in direct-output mode
    input wire logic seg_direct_mode,
    output logic [wkdsp_pkg::FLAG_W-1:0] seg_open_drain_ff,
    // Display read port for the waveform generator
    input wire logic [wkdsp_pkg::DISP_ADDR_W-1:0] disp_rd_addr,
    output logic [wkdsp_pkg::NIB_W-1:0] disp_rd_data_ff
);

    initial begin
        if (DISP_DEPTH < 1 || DISP_DEPTH > (1 << wkdsp_pkg::DISP_ADDR_W)) begin
            $error("wkdsp_exec: display depth does not fit the address field");
        end
        if (PORT_W < 1) begin
            $error("wkdsp_exec: port width must be at least one");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic [7:0] op8;
    logic [6:0] op7;
    logic [8:0] op9;
    logic [7:0] imm8;
    logic [wkdsp_pkg::NIB_W-1:0] imm4;
    logic [wkdsp_pkg::DISP_ADDR_W-1:0] disp_addr;
    logic dec_hold;
    logic dec_irq;
    logic dec_type;
    logic dec_disp_acc;
    logic dec_disp_wreg;
    logic dec_disp_imm;
    logic dec_load;

    assign op8 = instr_word[wkdsp_pkg::OP8_HI:wkdsp_pkg::OP8_LO];
    assign op7 = instr_word[wkdsp_pkg::OP7_HI:wkdsp_pkg::OP7_LO];
    assign op9 = instr_word[wkdsp_pkg::OP9_HI:wkdsp_pkg::OP9_LO];
    assign imm8 = instr_word[wkdsp_pkg::IMM8_HI:wkdsp_pkg::IMM8_LO];
    assign imm4 = instr_word[wkdsp_pkg::NIB_HI:wkdsp_pkg::NIB_LO];
    assign disp_addr = instr_word[wkdsp_pkg::DADDR_HI:wkdsp_pkg::DADDR_LO];

    // Prefixes are chosen so that no two overlap; the ACC form also needs a zero tail
    always_comb begin
        dec_hold = 1'b0;
        dec_irq = 1'b0;
        dec_type = 1'b0;
        dec_disp_acc = 1'b0;
        dec_disp_wreg = 1'b0;
        dec_disp_imm = 1'b0;
        dec_load = 1'b0;
        if (!instr_valid) begin
            dec_hold = 1'b0;
        end else if (op8 == wkdsp_pkg::OP8_HOLD_FLAGS) begin
            dec_hold = 1'b1;
        end else if (op8 == wkdsp_pkg::OP8_IRQ_FLAGS) begin
            dec_irq = 1'b1;
        end else if (op8 == wkdsp_pkg::OP8_OUT_TYPE) begin
            dec_type = 1'b1;
        end else if (op7 == wkdsp_pkg::OP7_DISP_FROM_ACC && imm4 == wkdsp_pkg::ACC_FORM_TAIL) begin
            dec_disp_acc = 1'b1;
        end else if (op7 == wkdsp_pkg::OP7_DISP_FROM_WREG) begin
            dec_disp_wreg = 1'b1;
        end else if (op7 == wkdsp_pkg::OP7_DISP_FROM_IMM) begin
            dec_disp_imm = 1'b1;
        end else if (op9 == wkdsp_pkg::OP9_ACC_FROM_MEM) begin
            dec_load = 1'b1;
        end
    end

    logic dec_any;
    logic dec_disp;

    assign dec_disp = dec_disp_acc | dec_disp_wreg | dec_disp_imm;
    assign dec_any = dec_hold | dec_irq | dec_type | dec_disp | dec_load;

    ////////////////////////////////////////////////////////////////////////////
    // Completion pulse and last operation

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_done_ff <= 1'b0;
        end else begin
            instr_done_ff <= dec_any;
        end
    end

    wkdsp_pkg::wkdsp_op_type nxt_last_op;

    always_comb begin
        if (dec_hold) begin
            nxt_last_op = wkdsp_pkg::WKDSP_OP_HOLD;
        end else if (dec_irq) begin
            nxt_last_op = wkdsp_pkg::WKDSP_OP_IRQ;
        end else if (dec_type) begin
            nxt_last_op = wkdsp_pkg::WKDSP_OP_TYPE;
        end else if (dec_disp) begin
            nxt_last_op = wkdsp_pkg::WKDSP_OP_DISP;
        end else if (dec_load) begin
            nxt_last_op = wkdsp_pkg::WKDSP_OP_LOAD;
        end else begin
            nxt_last_op = wkdsp_pkg::wkdsp_op_type'(last_op_ff);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_op_ff <= wkdsp_pkg::WKDSP_OP_NONE;
        end else begin
            last_op_ff <= nxt_last_op;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag registers

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_wake_enable_flags_ff <= wkdsp_pkg::HOLD_FLAGS_RST;
        end else if (dec_hold) begin
            hold_wake_enable_flags_ff <= imm8 & wkdsp_pkg::FLAG_IMPL_MASK;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_accept_flags_ff <= wkdsp_pkg::IRQ_FLAGS_RST;
        end else if (dec_irq) begin
            interrupt_accept_flags_ff <= imm8 & wkdsp_pkg::FLAG_IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment output type

    logic [wkdsp_pkg::FLAG_W-1:0] out_type_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_type_ff <= wkdsp_pkg::OUT_TYPE_RST;
        end else if (dec_type) begin
            out_type_ff <= imm8;
        end
    end

    // open-drain select
    // Outside direct mode the pins carry the LCD waveform, so no group is open-drain
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seg_open_drain_ff <= wkdsp_pkg::OUT_TYPE_RST;
        end else if (seg_direct_mode) begin
            seg_open_drain_ff <= dec_type ? imm8 : out_type_ff;
        end else begin
            seg_open_drain_ff <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port change detection

    logic [PORT_W-1:0] port_meta_ff;
    logic [PORT_W-1:0] port_sync_ff;
    logic [PORT_W-1:0] port_prev_ff;
    logic port_primed_ff;
    logic port_change;

    // Pins are asynchronous; the first stage feeds only the second
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_meta_ff <= '0;
            port_sync_ff <= '0;
        end else begin
            port_meta_ff <= change_detect_input_port;
            port_sync_ff <= port_meta_ff;
        end
    end

    // The primed bit masks only the first cycle after reset; a nonzero first synchronised sample still counts as a change
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_prev_ff <= '0;
            port_primed_ff <= 1'b0;
        end else begin
            port_prev_ff <= port_sync_ff;
            port_primed_ff <= 1'b1;
        end
    end

    assign port_change = port_primed_ff && (port_sync_ff != port_prev_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Event sources, hold release and interrupt acceptance

    logic [wkdsp_pkg::FLAG_W-1:0] event_vec;

    always_comb begin
        event_vec = '0;
        event_vec[wkdsp_pkg::SRC_DIV0] = div0_overflow;
        event_vec[wkdsp_pkg::SRC_TMR0] = tmr0_underflow;
        event_vec[wkdsp_pkg::SRC_PORT] = port_change;
        event_vec[wkdsp_pkg::SRC_DIV1] = div1_overflow;
        event_vec[wkdsp_pkg::SRC_TMR1] = tmr1_underflow;
    end

    logic [wkdsp_pkg::FLAG_W-1:0] wake_hit;

    for (genvar i = 0; i < wkdsp_pkg::FLAG_W; i++) begin : g_src
        if (wkdsp_pkg::FLAG_IMPL_MASK[i]) begin : g_impl
            assign wake_hit[i] = event_vec[i] & hold_wake_enable_flags_ff[i];
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    irq_accept_ff[i] <= 1'b0;
                end else begin
                    irq_accept_ff[i] <= event_vec[i] & interrupt_accept_flags_ff[i];
                end
            end
        end else begin : g_rsvd
            assign wake_hit[i] = 1'b0;
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    irq_accept_ff[i] <= 1'b0;
                end else begin
                    irq_accept_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_release_ff <= 1'b0;
        end else begin
            hold_release_ff <= in_hold & (|wake_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display RAM write

    logic disp_wr_en;
    logic [wkdsp_pkg::NIB_W-1:0] disp_wr_data;

    always_comb begin
        if (dec_disp_acc) begin
            disp_wr_data = accumulator;
        end else if (dec_disp_wreg) begin
            disp_wr_data = wreg_rd_data;
        end else begin
            disp_wr_data = imm4;
        end
    end

    assign disp_wr_en = dec_disp;

    wkdsp_nibble_ram #(
        .DEPTH(DISP_DEPTH),
        .ADDR_W(wkdsp_pkg::DISP_ADDR_W),
        .DATA_W(wkdsp_pkg::NIB_W)
    ) u_disp_ram (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(disp_wr_en),
        .wr_addr(disp_addr),
        .wr_data(disp_wr_data),
        .rd_addr(disp_rd_addr),
        .rd_data_ff(disp_rd_data_ff)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Memory to accumulator move

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_load_ff <= 1'b0;
        end else begin
            acc_load_ff <= dec_load;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_load_data_ff <= wkdsp_pkg::NIB_RST;
            zero_flag_ff <= 1'b0;
        end else if (dec_load) begin
            acc_load_data_ff <= mem_rd_data;
            zero_flag_ff <= (mem_rd_data == wkdsp_pkg::NIB_RST);
        end
    end

endmodule

`default_nettype wire

// [verif/wkdsp_core_model.sv]
// Model of the core datapath: working registers and data memory read in the instruction cycle
`timescale 1ns/1ps
`default_nettype none

module wkdsp_core_model (
    // Instruction word from the decoder
    input wire logic [wkdsp_pkg::INSTR_W-1:0] instr_word,
    // Operands read in the same cycle
    output logic [wkdsp_pkg::NIB_W-1:0] wreg_rd_data,
    output logic [wkdsp_pkg::NIB_W-1:0] mem_rd_data
);
    // Fixed contents, so the bench can predict every read without a copy of the arrays
    // selected working register
    assign wreg_rd_data = 4'hF - instr_word[3:0];
    // data memory at the seven-bit address
    assign mem_rd_data = 4'(instr_word[6:0] * 3);
endmodule

`default_nettype wire

// [verif/wkdsp_exec_props.sv]
// Assertions on flag loads, events, output type and the memory move at the block ports
`timescale 1ns/1ps
`default_nettype none

module wkdsp_exec_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Instruction side
    input wire logic instr_valid,
    input wire logic [wkdsp_pkg::INSTR_W-1:0] instr_word,
    input wire logic [wkdsp_pkg::NIB_W-1:0] mem_rd_data,
    input wire logic acc_load_ff,
    input wire logic [wkdsp_pkg::NIB_W-1:0] acc_load_data_ff,
    input wire logic zero_flag_ff,
    input wire logic instr_done_ff,
    // Events and hold
    input wire logic div0_overflow,
    input wire logic in_hold,
    input wire logic hold_release_ff,
    input wire logic [wkdsp_pkg::FLAG_W-1:0] irq_accept_ff,
    // Flags and output type
    input wire logic [wkdsp_pkg::FLAG_W-1:0] hold_wake_enable_flags_ff,
    input wire logic [wkdsp_pkg::FLAG_W-1:0] interrupt_accept_flags_ff,
    input wire logic seg_direct_mode,
    input wire logic [wkdsp_pkg::FLAG_W-1:0] seg_open_drain_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic is_hold;
    logic is_irq;
    logic is_type;
    logic is_mem;
    assign is_hold = instr_valid && instr_word[15:8] == wkdsp_pkg::OP8_HOLD_FLAGS;
    assign is_irq = instr_valid && instr_word[15:8] == wkdsp_pkg::OP8_IRQ_FLAGS;
    assign is_type = instr_valid && instr_word[15:8] == wkdsp_pkg::OP8_OUT_TYPE;
    assign is_mem = instr_valid && instr_word[15:7] == wkdsp_pkg::OP9_ACC_FROM_MEM;

    property p_hold_load;
        is_hold |=> hold_wake_enable_flags_ff == (8'($past(instr_word)) & 8'h97);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("hold flag load wrong");
    property p_irq_load;
        is_irq |=> interrupt_accept_flags_ff == (8'($past(instr_word)) & 8'h97);
    endproperty
    a_irq_load: assert property (p_irq_load) else $error("irq flag load wrong");
    property p_done;
        is_hold || is_irq || is_type || is_mem |=> instr_done_ff;
    endproperty
    a_done: assert property (p_done) else $error("no completion after one cycle");
    property p_wake0;
        div0_overflow && in_hold && hold_wake_enable_flags_ff[0] |=> hold_release_ff;
    endproperty
    a_wake0: assert property (p_wake0) else $error("divider zero did not release hold");
    property p_irq0;
        div0_overflow && interrupt_accept_flags_ff[0] |=> irq_accept_ff[0];
    endproperty
    a_irq0: assert property (p_irq0) else $error("divider zero irq not accepted");
    property p_hold_cause;
        hold_release_ff |-> $past(in_hold);
    endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("release outside hold");
    property p_type;
        is_type && seg_direct_mode |=> !seg_direct_mode || seg_open_drain_ff == 8'($past(instr_word));
    endproperty
    a_type: assert property (p_type) else $error("output type not loaded");
    property p_mem;
        is_mem |=> acc_load_ff && acc_load_data_ff == $past(mem_rd_data)
            && zero_flag_ff == ($past(mem_rd_data) == 4'h0);
    endproperty
    a_mem: assert property (p_mem) else $error("memory move result wrong");

    c_release: cover property (hold_release_ff);
    c_port_irq: cover property (irq_accept_ff[2]);
    c_mem_zero: cover property (acc_load_ff && zero_flag_ff);
endmodule

bind wkdsp_exec wkdsp_exec_props u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .mem_rd_data(mem_rd_data), .acc_load_ff(acc_load_ff), .acc_load_data_ff(acc_load_data_ff),
    .zero_flag_ff(zero_flag_ff), .instr_done_ff(instr_done_ff), .div0_overflow(div0_overflow),
    .in_hold(in_hold), .hold_release_ff(hold_release_ff), .irq_accept_ff(irq_accept_ff),
    .hold_wake_enable_flags_ff(hold_wake_enable_flags_ff), .interrupt_accept_flags_ff(interrupt_accept_flags_ff),
    .seg_direct_mode(seg_direct_mode), .seg_open_drain_ff(seg_open_drain_ff)
);

`default_nettype wire

// [verif/test_wakeup_irq_enable_lcd_ram_write_exec.sv]
// Self-checking bench for the wake, interrupt, output type and display write block
`timescale 1ns/1ps
`default_nettype none

module test_wakeup_irq_enable_lcd_ram_write_exec;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] accumulator = 4'h0;
    logic [3:0] ev = 4'h0;
    logic [3:0] port_pins = 4'h0;
    logic in_hold = 1'b0;
    logic seg_direct_mode = 1'b0;
    logic [4:0] disp_rd_addr = 5'h00;
    logic [3:0] wreg_rd_data, mem_rd_data, acc_load_data_ff, disp_rd_data_ff;
    logic acc_load_ff, zero_flag_ff, instr_done_ff, hold_release_ff;
    logic [2:0] last_op_ff;
    logic [7:0] irq_accept_ff, hold_flags, irq_flags, seg_open_drain_ff;
    int n_errors = 0;
    int checks_done = 0;

    always #2 core_clk = ~core_clk;

    wkdsp_core_model u_core (.instr_word(instr_word), .wreg_rd_data(wreg_rd_data), .mem_rd_data(mem_rd_data));

    wkdsp_exec DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .accumulator(accumulator), .wreg_rd_data(wreg_rd_data), .mem_rd_data(mem_rd_data),
        .acc_load_ff(acc_load_ff), .acc_load_data_ff(acc_load_data_ff), .zero_flag_ff(zero_flag_ff),
        .instr_done_ff(instr_done_ff), .last_op_ff(last_op_ff), .div0_overflow(ev[0]),
        .tmr0_underflow(ev[1]), .div1_overflow(ev[2]), .tmr1_underflow(ev[3]),
        .change_detect_input_port(port_pins), .in_hold(in_hold), .hold_release_ff(hold_release_ff),
        .irq_accept_ff(irq_accept_ff), .hold_wake_enable_flags_ff(hold_flags),
        .interrupt_accept_flags_ff(irq_flags), .seg_direct_mode(seg_direct_mode),
        .seg_open_drain_ff(seg_open_drain_ff), .disp_rd_addr(disp_rd_addr), .disp_rd_data_ff(disp_rd_data_ff)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One instruction cycle; outputs are looked at just after the taking edge
    task automatic issue(input logic [15:0] w, input logic [3:0] a);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        accumulator <= a;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_flags();
        logic [7:0] ops [4] = '{8'hFF, 8'h00, 8'h5A, 8'hA5};
        foreach (ops[i]) begin
            issue({wkdsp_pkg::OP8_HOLD_FLAGS, ops[i]}, 4'h0);
            chk("hold flags", ops[i] & 8'h97, hold_flags);
            chk("done", 8'h01, 8'(instr_done_ff));
            chk("last op", 8'h01, 8'(last_op_ff));
            issue({wkdsp_pkg::OP8_IRQ_FLAGS, ops[i]}, 4'h0);
            chk("irq flags", ops[i] & 8'h97, irq_flags);
            chk("last op", 8'h02, 8'(last_op_ff));
        end
        @(posedge core_clk);
        #1;
        chk("done pulse", 8'h00, 8'(instr_done_ff));
    endtask

    task automatic t_events();
        int src [4] = '{0, 1, 4, 7};
        logic [7:0] seen;
        issue({wkdsp_pkg::OP8_HOLD_FLAGS, 8'hFF}, 4'h0);
        issue({wkdsp_pkg::OP8_IRQ_FLAGS, 8'h97}, 4'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            in_hold <= (i < 4);
            ev <= 4'(1 << (i % 4));
            @(posedge core_clk);
            ev <= 4'h0;
            #1;
            chk("hold release", 8'(i < 4), 8'(hold_release_ff));
            chk("irq accept", 8'(1 << src[i % 4]), irq_accept_ff);
        end
        issue({wkdsp_pkg::OP8_HOLD_FLAGS, 8'h04}, 4'h0);
        issue({wkdsp_pkg::OP8_IRQ_FLAGS, 8'h04}, 4'h0);
        @(posedge core_clk);
        in_hold <= 1'b1;
        ev <= 4'hF;
        @(posedge core_clk);
        ev <= 4'h0;
        port_pins <= 4'h8;
        seen = 8'h00;
        #1;
        chk("masked events", 8'h00, {irq_accept_ff[7:1], hold_release_ff});
        // Pin changes pass a synchroniser, so the answer is gathered over a short span
        repeat (8) begin
            @(posedge core_clk);
            #1;
            seen |= {irq_accept_ff[7:1], hold_release_ff};
        end
        chk("port wake and irq", 8'h05, seen);
        in_hold <= 1'b0;
    endtask

    task automatic t_type();
        @(posedge core_clk);
        seg_direct_mode <= 1'b1;
        issue({wkdsp_pkg::OP8_OUT_TYPE, 8'hC3}, 4'h0);
        chk("open drain", 8'hC3, seg_open_drain_ff);
        chk("last op", 8'h03, 8'(last_op_ff));
        issue({wkdsp_pkg::OP8_OUT_TYPE, 8'h3C}, 4'h0);
        chk("open drain", 8'h3C, seg_open_drain_ff);
        @(posedge core_clk);
        seg_direct_mode <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("open drain off", 8'h00, seg_open_drain_ff);
    endtask

    task automatic t_disp();
        logic [15:0] w [3] = '{{wkdsp_pkg::OP7_DISP_FROM_ACC, 5'h00, 4'h0},
            {wkdsp_pkg::OP7_DISP_FROM_WREG, 5'h1F, 4'h2}, {wkdsp_pkg::OP7_DISP_FROM_IMM, 5'h0A, 4'h5}};
        logic [4:0] a [3] = '{5'h00, 5'h1F, 5'h0A};
        logic [3:0] e [3] = '{4'h9, 4'hD, 4'h5};
        foreach (w[i]) begin
            issue(w[i], 4'h9);
            chk("last op", 8'h04, 8'(last_op_ff));
        end
        foreach (a[i]) begin
            @(posedge core_clk);
            disp_rd_addr <= a[i];
            @(posedge core_clk);
            #1;
            chk("display ram", 8'(e[i]), 8'(disp_rd_data_ff));
        end
    endtask

    task automatic t_mem();
        issue({wkdsp_pkg::OP9_ACC_FROM_MEM, 7'h00}, 4'h7);
        chk("acc load", 8'h01, 8'(acc_load_ff));
        chk("acc data", 8'h00, 8'(acc_load_data_ff));
        chk("zero flag", 8'h01, 8'(zero_flag_ff));
        issue({wkdsp_pkg::OP9_ACC_FROM_MEM, 7'h7F}, 4'h0);
        chk("acc data", 8'h0D, 8'(acc_load_data_ff));
        chk("zero flag", 8'h00, 8'(zero_flag_ff));
        chk("last op", 8'h05, 8'(last_op_ff));
        issue(16'hFFFF, 4'h0);
        chk("refused done", 8'h00, 8'(instr_done_ff));
        chk("refused last op", 8'h05, 8'(last_op_ff));
        @(posedge core_clk);
        #1;
        chk("acc load pulse", 8'h00, 8'(acc_load_ff));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_flags();
        t_events();
        t_type();
        t_disp();
        t_mem();
        end_of_test();
    end

    // The sequence needs under a hundred cycles; this is about sixty times that
    initial begin
        #20000;
        n_errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
